// >>> hdl/hrs_contact_if.sv
/*
 * Carrier between the sequencer and its stopper contact timer.
 * Assumes both ends share sys_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
interface hrs_contact_if;
	import hrs_pkg::*;
	logic arm;
	logic [HRS_TORQUE_W-1:0] torque_pct;
	logic [HRS_TORQUE_W-1:0] threshold_pct;
	logic [HRS_TIME_W-1:0] time_ms;
	logic contact;
	modport seq (output arm, output torque_pct, output threshold_pct, output time_ms,
		input contact);
	modport timer (input arm, input torque_pct, input threshold_pct, input time_ms,
		output contact);
endinterface : hrs_contact_if
`default_nettype wire

// >>> hdl/hrs_contact_timer.sv
/*
 * Stopper contact timer: flags contact once torque has stayed above the
 * threshold for the set number of milliseconds while armed.
 * Assumes a millisecond length given in clock cycles by the parent.
 */
`timescale 1ns/1ns
`default_nettype none
module hrs_contact_timer
	import hrs_pkg::*;
#(
	parameter int MS_CYCLES = HRS_MS_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	hrs_contact_if.timer ct
);
	logic [HRS_DIV_W-1:0] div_reg;
	logic [HRS_TIME_W-1:0] ms_reg;
	logic contact_reg;
	wire logic over = ct.arm && (ct.torque_pct > ct.threshold_pct);
	wire logic tick = (div_reg == HRS_DIV_W'(MS_CYCLES - 1));
	wire logic reached = (ms_reg >= ct.time_ms);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !over) begin
			div_reg <= '0;
			ms_reg <= '0;
			contact_reg <= 1'b0;
		end else begin
			div_reg <= tick ? '0 : div_reg + 1'b1;
			if (tick && !reached)
				ms_reg <= ms_reg + 1'b1;
			contact_reg <= reached;
		end
	end
	assign ct.contact = contact_reg;

	chk_contact_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!over |=> !ct.contact) else $error("contact flagged without torque");
endmodule : hrs_contact_timer
`default_nettype wire

// >>> hdl/hrs_pkg.sv
/*
 * Shared constants and types of the home return sequencer: method codes,
 * sequencer states, follow-up codes after a deceleration stop, timing.
 * Assumes a single 125 MHz clock.
 */
package hrs_pkg;
	localparam int HRS_METHOD_W = 4;
	localparam int HRS_METHOD_COUNT = 10;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_FRONT_IDX = 4'h0; // front_edge_index_mode
	localparam logic [HRS_METHOD_W-1:0] HRS_M_FRONT_SW = 4'h1; // front_edge_switch_mode
	localparam logic [HRS_METHOD_W-1:0] HRS_M_BACK_IDX = 4'h2; // back_edge_index_mode
	localparam logic [HRS_METHOD_W-1:0] HRS_M_BACK_SW = 4'h3; // back_edge_switch_mode
	localparam logic [HRS_METHOD_W-1:0] HRS_M_LIMIT_IDX = 4'h4;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_LIMIT = 4'h5;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_INDEX = 4'h6;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_STOPPER = 4'h7;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_STOPPER_IDX = 4'h8;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_DATA_SET = 4'h9;
	localparam logic [HRS_METHOD_W-1:0] HRS_M_LAST = 4'h9;

	localparam int HRS_TORQUE_W = 8;
	localparam int HRS_TIME_W = 16;

	localparam int HRS_CLK_PERIOD_NS = 8;
	localparam int HRS_TICK_MS = 1;
	localparam int HRS_MS_CYCLES = (HRS_TICK_MS * 1000000) / HRS_CLK_PERIOD_NS;
	localparam int HRS_DIV_W = 24;

	typedef enum logic [2:0] {
		HRS_IDLE = 3'b000,
		HRS_SEARCH = 3'b001,
		HRS_REVERSE = 3'b010,
		HRS_DECEL = 3'b011,
		HRS_CREEP = 3'b100,
		HRS_SERVO = 3'b101,
		HRS_CONTACT = 3'b110,
		HRS_FINISH = 3'b111
	} hrs_state_t;

	typedef enum logic [1:0] {
		HRS_AFT_FINISH = 2'b00,
		HRS_AFT_CREEP = 2'b01,
		HRS_AFT_SERVO = 2'b10,
		HRS_AFT_ABORT = 2'b11
	} hrs_after_t;
endpackage : hrs_pkg

// >>> hdl/hrs_sequencer.sv
/*
 * Per-axis home return sequencer: ten homing methods, servo index search
 * hand-off, stopper detection, busy and done flags, coordinate zeroing.
 * Assumes inputs synchronous to sys_clk_i, one sample per control cycle,
 * and a motion generator that reports when a commanded stop has ended.
 */
`timescale 1ns/1ns
`default_nettype none
module hrs_sequencer
	import hrs_pkg::*;
#(
	parameter int MS_CYCLES = HRS_MS_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic start_req_i,
	input wire logic [HRS_METHOD_W-1:0] method_i,
	input wire logic home_dir_pos_i,
	input wire logic other_op_start_i,
	input wire logic stop_req_i,
	input wire logic near_home_i,
	input wire logic limit_pos_i,
	input wire logic limit_neg_i,
	input wire logic motion_stopped_i,
	input wire logic servo_done_i,
	input wire logic [HRS_TORQUE_W-1:0] torque_pct_i,
	input wire logic [HRS_TORQUE_W-1:0] contact_torque_pct_i,
	input wire logic [HRS_TIME_W-1:0] contact_time_ms_i,
	output logic move_en_o,
	output logic move_dir_pos_o,
	output logic creep_o,
	output logic stop_cmd_o,
	output logic servo_search_o,
	output logic servo_search_pos_o,
	output logic coord_zero_o,
	output logic busy_o,
	output logic done_o,
	output logic cfg_err_o
);
	hrs_state_t state_reg, state_next;
	hrs_after_t after_reg, after_next;
	logic [HRS_METHOD_W-1:0] method_reg;
	logic home_pos_reg;
	logic dir_reg, dir_next;
	logic start_q, home_q, lim_pos_q, lim_neg_q;

	hrs_contact_if ct_if ();
	hrs_contact_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ct(ct_if.timer)
	);
	assign ct_if.arm = (state_reg == HRS_CONTACT);
	assign ct_if.torque_pct = torque_pct_i;
	assign ct_if.threshold_pct = contact_torque_pct_i;
	assign ct_if.time_ms = contact_time_ms_i;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			start_q <= 1'b0;
			home_q <= 1'b0;
			lim_pos_q <= 1'b0;
			lim_neg_q <= 1'b0;
		end else begin
			start_q <= start_req_i;
			home_q <= near_home_i;
			lim_pos_q <= limit_pos_i;
			lim_neg_q <= limit_neg_i;
		end
	end

	wire logic start_rise = start_req_i && !start_q;
	wire logic method_ok = (method_i <= HRS_M_LAST);
	wire logic accept = start_rise && (state_reg == HRS_IDLE) && method_ok;
	wire logic reject = start_rise && (state_reg == HRS_IDLE) && !method_ok;
	wire logic home_rise = near_home_i && !home_q;
	wire logic home_fall = !near_home_i && home_q;
	wire logic lim_home = home_pos_reg ? limit_pos_i : limit_neg_i;
	wire logic lim_home_q = home_pos_reg ? lim_pos_q : lim_neg_q;
	wire logic lim_opp = home_pos_reg ? limit_neg_i : limit_pos_i;
	wire logic lim_opp_q = home_pos_reg ? lim_neg_q : lim_pos_q;
	wire logic lim_home_rise = lim_home && !lim_home_q;
	wire logic lim_opp_rise = lim_opp && !lim_opp_q;
	wire logic lim_opp_fall = !lim_opp && lim_opp_q;
	wire logic is_front = (method_reg == HRS_M_FRONT_IDX) || (method_reg == HRS_M_FRONT_SW);
	wire logic is_back = (method_reg == HRS_M_BACK_IDX) || (method_reg == HRS_M_BACK_SW);
	wire logic idx_after = (method_reg == HRS_M_FRONT_IDX) || (method_reg == HRS_M_BACK_IDX)
		|| (method_reg == HRS_M_LIMIT_IDX) || (method_reg == HRS_M_STOPPER_IDX);
	wire logic sw_after = (method_reg == HRS_M_FRONT_SW) || (method_reg == HRS_M_BACK_SW);
	wire logic trigger = (is_front && home_rise) || (is_back && home_fall)
		|| ((method_reg == HRS_M_LIMIT) && lim_home_rise);
	wire logic abortable = (state_reg != HRS_IDLE) && (state_reg != HRS_SERVO)
		&& (state_reg != HRS_FINISH) && (state_reg != HRS_DECEL);

	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		dir_next = dir_reg;
		if (stop_req_i && abortable) begin
			state_next = HRS_DECEL;
			after_next = HRS_AFT_ABORT;
		end else begin
			unique case (state_reg)
				HRS_IDLE: begin
					if (accept) begin
						dir_next = home_dir_pos_i;
						unique case (method_i)
							HRS_M_DATA_SET: state_next = HRS_FINISH;
							HRS_M_INDEX: state_next = HRS_SERVO;
							HRS_M_STOPPER, HRS_M_STOPPER_IDX: state_next = HRS_CONTACT;
							HRS_M_LIMIT_IDX: begin
								state_next = HRS_SEARCH;
								dir_next = !home_dir_pos_i;
							end
							default: state_next = HRS_SEARCH;
						endcase
					end
				end
				HRS_SEARCH: begin
					if (method_reg == HRS_M_LIMIT_IDX) begin
						if (lim_opp_rise) begin
							state_next = HRS_REVERSE;
							dir_next = home_pos_reg;
						end
					end else if (trigger) begin
						state_next = HRS_DECEL;
						after_next = idx_after ? HRS_AFT_SERVO
							: (sw_after ? HRS_AFT_CREEP : HRS_AFT_FINISH);
					end
				end
				HRS_REVERSE: begin
					if (lim_opp_fall) begin
						state_next = HRS_DECEL;
						after_next = HRS_AFT_SERVO;
					end
				end
				HRS_CONTACT: begin
					if (ct_if.contact) begin
						state_next = HRS_DECEL;
						after_next = (method_reg == HRS_M_STOPPER_IDX) ? HRS_AFT_SERVO
							: HRS_AFT_FINISH;
					end
				end
				HRS_DECEL: begin
					if (motion_stopped_i) begin
						unique case (after_reg)
							HRS_AFT_FINISH: state_next = HRS_FINISH;
							HRS_AFT_ABORT: state_next = HRS_IDLE;
							HRS_AFT_CREEP: begin
								state_next = HRS_CREEP;
								dir_next = !home_pos_reg;
							end
							HRS_AFT_SERVO: begin
								state_next = HRS_SERVO;
								dir_next = (method_reg == HRS_M_STOPPER_IDX) ? !home_pos_reg
									: home_pos_reg;
							end
						endcase
					end
				end
				HRS_CREEP: begin
					if (home_rise) begin
						state_next = HRS_DECEL;
						after_next = HRS_AFT_FINISH;
					end
				end
				HRS_SERVO: begin
					if (servo_done_i)
						state_next = HRS_FINISH;
				end
				HRS_FINISH: state_next = HRS_IDLE;
			endcase
		end
	end

	wire logic moving_next = (state_next == HRS_SEARCH) || (state_next == HRS_REVERSE)
		|| (state_next == HRS_CREEP) || (state_next == HRS_CONTACT);
	wire logic creep_next = (state_next == HRS_CREEP) || (state_next == HRS_CONTACT);
	wire logic done_next = (state_reg == HRS_FINISH)
		|| (done_o && !accept && !other_op_start_i);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= HRS_IDLE;
			after_reg <= HRS_AFT_FINISH;
			method_reg <= HRS_M_FRONT_IDX;
			home_pos_reg <= 1'b0;
			dir_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			dir_reg <= dir_next;
			if (accept) begin
				method_reg <= method_i;
				home_pos_reg <= home_dir_pos_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			move_en_o <= 1'b0;
			move_dir_pos_o <= 1'b0;
			creep_o <= 1'b0;
			stop_cmd_o <= 1'b0;
			servo_search_o <= 1'b0;
			servo_search_pos_o <= 1'b0;
			coord_zero_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			cfg_err_o <= 1'b0;
		end else begin
			move_en_o <= moving_next;
			move_dir_pos_o <= dir_next;
			creep_o <= creep_next;
			stop_cmd_o <= (state_next == HRS_DECEL);
			servo_search_o <= (state_next == HRS_SERVO);
			servo_search_pos_o <= dir_next;
			coord_zero_o <= (state_next == HRS_FINISH);
			busy_o <= (state_next != HRS_IDLE);
			done_o <= done_next;
			cfg_err_o <= reject;
		end
	end

	chk_bad_method: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		reject |=> cfg_err_o && !busy_o) else $error("illegal method started");
	chk_zero_then_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		coord_zero_o |=> done_o && !busy_o) else $error("zeroing without done");
	chk_front_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_SEARCH) && is_front && home_rise && !stop_req_i
		|=> stop_cmd_o && !move_en_o) else $error("front edge not stopped");
	chk_servo_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(servo_search_o) && (method_reg != HRS_M_STOPPER_IDX)
		|-> servo_search_pos_o == home_pos_reg) else $error("index search direction");
	chk_creep_back: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_CREEP) |-> creep_o && move_en_o
		&& (move_dir_pos_o != home_pos_reg)) else $error("creep not reversed");
	chk_back_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_SEARCH) && is_back && home_fall && !stop_req_i
		|=> stop_cmd_o) else $error("back edge not stopped");
	chk_limit_rev: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_SEARCH) && (method_reg == HRS_M_LIMIT_IDX) && lim_opp_rise
		&& !stop_req_i |=> move_en_o && (move_dir_pos_o == home_pos_reg))
		else $error("limit reverse missing");
	chk_limit_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_SEARCH) && (method_reg == HRS_M_LIMIT) && lim_home_rise
		&& !stop_req_i |=> stop_cmd_o) else $error("limit stop missing");
	chk_index_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		accept && (method_i == HRS_M_INDEX) |=> servo_search_o
		&& (servo_search_pos_o == $past(home_dir_pos_i))) else $error("index search start");
	chk_stopper_rev: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(servo_search_o) && (method_reg == HRS_M_STOPPER_IDX)
		|-> servo_search_pos_o != home_pos_reg) else $error("stopper not reversed");
	chk_data_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		accept && (method_i == HRS_M_DATA_SET) |=> coord_zero_o && !move_en_o
		##1 done_o) else $error("data set failed");
	chk_edge_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(busy_o) |-> $past(start_rise)) else $error("start without edge");
	chk_busy_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		accept |=> busy_o && !done_o) else $error("busy not raised");
	chk_servo_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == HRS_SERVO) && !servo_done_i |=> servo_search_o && busy_o)
		else $error("servo search interrupted");
endmodule : hrs_sequencer
`default_nettype wire

// >>> test/hrs_servo_model.sv
/*
 * Far side model: motion generator stop reply and amplifier index search.
 * Assumes the sequencer's clock and synchronous reset; delay set by the bench.
 */
`timescale 1ns/1ns
`default_nettype none
module hrs_servo_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] delay_i,
	input wire logic stop_cmd_i,
	input wire logic search_i,
	output logic motion_stopped_o,
	output logic servo_done_o
);
	logic [3:0] stop_cnt_reg;
	logic [3:0] search_cnt_reg;
	// Stop ends after the set delay, held until released
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !stop_cmd_i) begin
			stop_cnt_reg <= 4'h0;
			motion_stopped_o <= 1'b0;
		end else if (stop_cnt_reg >= delay_i) begin
			motion_stopped_o <= 1'b1;
		end else begin
			stop_cnt_reg <= stop_cnt_reg + 4'h1;
		end
	end
	// Search owns the motion: no stop input reaches it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !search_i) begin
			search_cnt_reg <= 4'h0;
			servo_done_o <= 1'b0;
		end else if (search_cnt_reg >= delay_i) begin
			servo_done_o <= 1'b1;
		end else begin
			search_cnt_reg <= search_cnt_reg + 4'h1;
		end
	end
endmodule : hrs_servo_model
`default_nettype wire

// >>> test/test_home_return_sequencer.sv
/*
 * Self-checking bench of the home return sequencer with a far side model.
 * Assumes a 125 MHz clock; inputs change on the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module test_home_return_sequencer;
	import hrs_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic start_req = 1'b0;
	logic [3:0] method = 4'h0;
	logic dir = 1'b0;
	logic other_op = 1'b0;
	logic stop_req = 1'b0;
	logic near = 1'b0;
	logic lim_pos = 1'b0;
	logic lim_neg = 1'b0;
	logic [7:0] torque = 8'h00;
	logic [3:0] dly = 4'h2;
	logic m_stopped, s_done, move_en_o, move_dir_pos_o, creep_o, stop_cmd_o;
	logic servo_search_o, servo_search_pos_o, coord_zero_o, busy_o, done_o, cfg_err_o;
	logic [7:0] zcnt = 8'h00;
	logic [7:0] ecnt = 8'h00;
	logic [7:0] z0;
	logic [7:0] e0;
	int fails = 0;
	int cmp_count = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (coord_zero_o === 1'b1) zcnt <= zcnt + 8'h01;
		if (cfg_err_o === 1'b1) ecnt <= ecnt + 8'h01;
	end
	hrs_sequencer #(.MS_CYCLES(10)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.start_req_i(start_req), .method_i(method), .home_dir_pos_i(dir),
		.other_op_start_i(other_op), .stop_req_i(stop_req), .near_home_i(near),
		.limit_pos_i(lim_pos), .limit_neg_i(lim_neg), .motion_stopped_i(m_stopped),
		.servo_done_i(s_done), .torque_pct_i(torque), .contact_torque_pct_i(8'h32),
		.contact_time_ms_i(16'h0002), .move_en_o(move_en_o),
		.move_dir_pos_o(move_dir_pos_o), .creep_o(creep_o), .stop_cmd_o(stop_cmd_o),
		.servo_search_o(servo_search_o), .servo_search_pos_o(servo_search_pos_o),
		.coord_zero_o(coord_zero_o), .busy_o(busy_o), .done_o(done_o), .cfg_err_o(cfg_err_o));
	hrs_servo_model far (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .delay_i(dly),
		.stop_cmd_i(stop_cmd_o), .search_i(servo_search_o),
		.motion_stopped_o(m_stopped), .servo_done_o(s_done));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : cyc
	task start(input logic [3:0] m, input logic d, input logic eb);
		z0 = zcnt;
		e0 = ecnt;
		method = m;
		dir = d;
		start_req = 1'b1;
		cyc(1);
		start_req = 1'b0;
		chk("busy", eb, busy_o);
		if (eb) chk("done", 1'b0, done_o);
	endtask : start
	task wait_stop;
		for (int i = 0; i < 200 && stop_cmd_o !== 1'b1; i++) cyc(1);
		chk("stop_cmd", 1'b1, stop_cmd_o);
	endtask : wait_stop
	task wait_creep(input logic ed);
		for (int i = 0; i < 200 && creep_o !== 1'b1; i++) cyc(1);
		chk("creep_dir", {ed, 2'b11}, {move_dir_pos_o, move_en_o, creep_o});
	endtask : wait_creep
	task wait_servo(input logic ep);
		for (int i = 0; i < 200 && servo_search_o !== 1'b1; i++) cyc(1);
		chk("servo_pos", {1'b1, ep}, {servo_search_o, servo_search_pos_o});
	endtask : wait_servo
	task wait_end(input logic ed);
		for (int i = 0; i < 200 && busy_o !== 1'b0; i++) cyc(1);
		chk("busy_end", 1'b0, busy_o);
		chk("done", ed, done_o);
		chk("zero_pulses", {7'h00, ed}, zcnt - z0);
	endtask : wait_end
	task t_data_set_and_level;
		// Request stays high throughout to prove level does not restart
		z0 = zcnt;
		method = HRS_M_DATA_SET;
		dir = 1'b0;
		start_req = 1'b1;
		cyc(1);
		chk("busy", 1'b1, busy_o);
		chk("done", 1'b0, done_o);
		chk("no_move", 1'b0, move_en_o);
		wait_end(1'b1);
		cyc(10);
		chk("level_no_restart", 1'b0, busy_o);
		chk("done_held", 1'b1, done_o);
		other_op = 1'b1;
		start_req = 1'b0;
		cyc(2);
		other_op = 1'b0;
		chk("done_cleared", 1'b0, done_o);
		$display("test data_set_and_level finished");
	endtask : t_data_set_and_level
	task t_bad_code;
		start(4'ha, 1'b0, 1'b0);
		cyc(2);
		chk("cfg_err", 8'h01, ecnt - e0);
		$display("test bad_code finished");
	endtask : t_bad_code
	task t_front_index;
		dly = 4'h6;
		start(HRS_M_FRONT_IDX, 1'b0, 1'b1);
		chk("dir", 2'b01, {move_dir_pos_o, move_en_o});
		near = 1'b1;
		wait_stop;
		wait_servo(1'b0);
		stop_req = 1'b1;
		cyc(3);
		chk("stop_ignored", 1'b0, stop_cmd_o);
		wait_end(1'b1);
		stop_req = 1'b0;
		near = 1'b0;
		dly = 4'h0;
		$display("test front_index finished");
	endtask : t_front_index
	task t_switch(input logic [3:0] m, input logic d, input logic back);
		start(m, d, 1'b1);
		near = 1'b1;
		cyc(2);
		if (back) near = 1'b0;
		wait_stop;
		wait_creep(~d);
		near = 1'b0;
		cyc(2);
		near = 1'b1;
		wait_stop;
		wait_end(1'b1);
		near = 1'b0;
		$display("test switch mode finished");
	endtask : t_switch
	task t_back_index;
		start(HRS_M_BACK_IDX, 1'b1, 1'b1);
		near = 1'b1;
		cyc(3);
		chk("no_stop_on_rise", 1'b0, stop_cmd_o);
		near = 1'b0;
		wait_stop;
		wait_servo(1'b1);
		wait_end(1'b1);
		$display("test back_index finished");
	endtask : t_back_index
	task t_limits;
		start(HRS_M_LIMIT_IDX, 1'b1, 1'b1);
		chk("dir_away", 1'b0, move_dir_pos_o);
		lim_neg = 1'b1;
		cyc(3);
		chk("dir_back", 2'b11, {move_dir_pos_o, move_en_o});
		lim_neg = 1'b0;
		wait_stop;
		wait_servo(1'b1);
		wait_end(1'b1);
		start(HRS_M_LIMIT, 1'b0, 1'b1);
		lim_neg = 1'b1;
		wait_stop;
		wait_end(1'b1);
		lim_neg = 1'b0;
		start(HRS_M_INDEX, 1'b1, 1'b1);
		wait_servo(1'b1);
		wait_end(1'b1);
		$display("test limits_and_index finished");
	endtask : t_limits
	task t_stopper;
		start(HRS_M_STOPPER, 1'b1, 1'b1);
		chk("creep", 2'b11, {creep_o, move_dir_pos_o});
		torque = 8'h32;
		cyc(30);
		chk("equal_no_contact", 1'b0, stop_cmd_o);
		torque = 8'h33;
		cyc(16);
		chk("early_contact", 1'b0, stop_cmd_o);
		wait_stop;
		wait_end(1'b1);
		start(HRS_M_STOPPER_IDX, 1'b1, 1'b1);
		wait_stop;
		wait_servo(1'b0);
		wait_end(1'b1);
		torque = 8'h00;
		$display("test stopper finished");
	endtask : t_stopper
	task t_abort;
		start(HRS_M_LIMIT, 1'b1, 1'b1);
		cyc(3);
		stop_req = 1'b1;
		wait_stop;
		stop_req = 1'b0;
		wait_end(1'b0);
		$display("test abort finished");
	endtask : t_abort
	initial begin
		cyc(16);
		rst_i = 1'b0;
		t_data_set_and_level;
		t_bad_code;
		t_front_index;
		t_switch(HRS_M_FRONT_SW, 1'b1, 1'b0);
		t_switch(HRS_M_BACK_SW, 1'b0, 1'b1);
		t_back_index;
		t_limits;
		t_stopper;
		t_abort;
		report_and_stop;
	end
	initial begin
		#160000;
		fails++;
		report_and_stop;
	end
endmodule : test_home_return_sequencer
`default_nettype wire
